// file: core/audio_path_defs.vh
// Behaviour
// - Word1 D10:D9 selects first mixer input
// - Word1 D8:D7 set first summer mode
// - Word1 D4 selects filter input source
// - Word1 D1 powers filter down when one
// - Word1 D3:D2 pick sample rate, filter
// - Word1 D6:D5 set second summer mode
// - Record input always from second summer
// - Word1 D0 powers mic gain amp down
// - Word0 D9 selects input source
// - Word1 D15:D14 select volume input
// - Word0 D0 powers attenuator down
// - Word1 D13:D11 give attenuation code
// - Word0 D4:D3 select output path
// - Word0 D2:D1 set speaker, aux mode
// - Word0 before word1; apply on SCL rise
// - Word0 D8:D6 analog out select, D5 power
`ifndef AUDIO_PATH_DEFS_VH
`define AUDIO_PATH_DEFS_VH
`define CFG_WIDTH          16
`define CFG_WORD0_RESET    16'h0000
`define CFG_WORD1_RESET    16'h0000
// Word0 fields
`define W0_ATTN_PD         0
`define W0_SPK_MODE_LO     1
`define W0_SPK_MODE_HI     2
`define W0_OUT_SEL_LO      3
`define W0_OUT_SEL_HI      4
`define W0_AOUT_PD         5
`define W0_AOUT_SEL_LO     6
`define W0_AOUT_SEL_HI     8
`define W0_IN_SRC_SEL      9
// Word1 fields
`define W1_MIC_PD          0
`define W1_FILT_PD         1
`define W1_RATE_LO         2
`define W1_RATE_HI         3
`define W1_FILT_SEL        4
`define W1_SECOND_SUMMING_AMP_LO         5
`define W1_SECOND_SUMMING_AMP_HI         6
`define W1_FIRST_SUMMING_AMP_LO         7
`define W1_FIRST_SUMMING_AMP_HI         8
`define W1_MIX1_LO         9
`define W1_MIX1_HI         10
`define W1_ATTN_LO         11
`define W1_ATTN_HI         13
`define W1_VOL_LO          14
`define W1_VOL_HI          15
// Record input source code: second summer
`define REC_SRC_SECOND_SUMMING_AMP       1'b1
`endif

// file: core/config_word_reg.v
`timescale 1ns/1ns
`default_nettype none
// One configuration word, updated only on its load strobe
module config_word_reg
#(
    parameter WIDTH             = 16,
    parameter [WIDTH-1:0] RESET = {WIDTH{1'b0}}
)
(
    input  wire             clock_i,    // System clock
    input  wire             reset_n_i,  // Synchronous reset, active low
    input  wire             load_i,     // One-cycle load strobe
    input  wire [WIDTH-1:0] data_i,     // New word
    output reg  [WIDTH-1:0] word_o      // Held word
);
    // Word holds between loads so decoded controls stay stable
    always @(posedge clock_i)
    begin
        if (!reset_n_i)
            word_o <= RESET;
        else if (load_i)
            word_o <= data_i;
    end
endmodule
`default_nettype wire

// file: core/audio_path_config_decode.v
`timescale 1ns/1ns
`default_nettype none
`include "audio_path_defs.vh"
// Holds the two audio path words and decodes them into path controls.
// Loads arrive as byte-assembled words from the serial port logic with a
// strobe that stages them until the next SCL rising edge, where they take effect.
module audio_path_config_decode
#(
    parameter W = `CFG_WIDTH
)
(
    input  wire         clock_i,                 // 50 MHz clock
    input  wire         reset_n_i,               // Sync reset, active low
    input  wire         scl_i,                   // Serial clock pin
    input  wire         load_word0_i,            // Word0 pending
    input  wire         load_word1_i,            // Word1 pending
    input  wire [W-1:0] load_data0_i,            // Word0 data
    input  wire [W-1:0] load_data1_i,            // Word1 data
    output wire [W-1:0] audio_path_config_word0_o, // Read back word0
    output wire [W-1:0] audio_path_config_word1_o, // Read back word1
    output reg  [1:0]   first_mixer_input_sel_o, // First mixer mux
    output reg  [1:0]   first_summer_mode_o,     // First summer mode
    output reg          filter_input_sel_o,      // 0 summer, 1 array
    output reg          filter_power_down_o,     // Filter off when high
    output reg  [1:0]   sample_rate_sel_o,       // 00 8.0,01 6.4,10 5.3
    output reg  [1:0]   second_summer_mode_o,    // Second summer mode
    output reg          record_src_sel_o,        // Always second summer
    output reg          mic_gain_amp_power_down_o, // Mic amp off
    output reg          input_source_sel_o,      // 0 mic gain amp
    output reg  [1:0]   volume_input_sel_o,      // Volume mux
    output reg          attenuator_power_down_o, // Attenuator off
    output reg  [2:0]   attenuation_level_o,     // Attenuation code
    output reg  [1:0]   output_path_sel_o,       // 00 attenuator
    output reg  [1:0]   speaker_drive_mode_o,    // Speaker / aux mode
    output reg  [2:0]   analog_out_sel_o,        // 000 feed-through
    output reg          analog_out_power_down_o  // Analog out amp off
);
    reg       scl_meta_q;   // First synchroniser stage
    reg       scl_sync_q;   // Second synchroniser stage
    reg       scl_prev_q;   // Previous synced level
    reg       pend0_q;      // Word0 waiting for SCL edge
    reg       pend1_q;      // Word1 waiting for SCL edge
    reg [W-1:0] stage0_q;   // Staged word0
    reg [W-1:0] stage1_q;   // Staged word1
    wire      scl_rise;     // One-cycle SCL rising edge
    wire [W-1:0] w0;        // Live word0
    wire [W-1:0] w1;        // Live word1

    // SCL comes from a pin, so two flops before edge detection
    always @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            scl_meta_q <= 1'b0;
            scl_sync_q <= 1'b0;
            scl_prev_q <= 1'b0;
        end
        else
        begin
            scl_meta_q <= scl_i;
            scl_sync_q <= scl_meta_q;
            scl_prev_q <= scl_sync_q;
        end
    end

    assign scl_rise = scl_sync_q & ~scl_prev_q;

    // Stage each word; a new strobe overwrites an unapplied one
    always @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            pend0_q  <= 1'b0;
            pend1_q  <= 1'b0;
            stage0_q <= `CFG_WORD0_RESET;
            stage1_q <= `CFG_WORD1_RESET;
        end
        else
        begin
            // Word0 staged: host must follow with word1
            if (load_word0_i)
            begin
                stage0_q <= load_data0_i;
                pend0_q  <= 1'b1;
            end
            else if (scl_rise)
                pend0_q <= 1'b0;
            if (load_word1_i)
            begin
                stage1_q <= load_data1_i;
                pend1_q  <= 1'b1;
            end
            else if (scl_rise)
                pend1_q <= 1'b0;
        end
    end

    // Both staged words commit together on the SCL rising edge; a lone
    // word1 commits alone, which is legal while word0 is unchanged
    config_word_reg #(.WIDTH(W), .RESET(`CFG_WORD0_RESET)) u_word0
    (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .load_i    (pend0_q & scl_rise),
        .data_i    (stage0_q),
        .word_o    (w0)
    );

    config_word_reg #(.WIDTH(W), .RESET(`CFG_WORD1_RESET)) u_word1
    (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .load_i    (pend1_q & scl_rise),
        .data_i    (stage1_q),
        .word_o    (w1)
    );

    assign audio_path_config_word0_o = w0;
    assign audio_path_config_word1_o = w1;

    // Decode registered so control outputs come from flops
    always @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            first_mixer_input_sel_o   <= 2'h0;
            first_summer_mode_o       <= 2'h0;
            filter_input_sel_o        <= 1'b0;
            filter_power_down_o       <= 1'b0;
            sample_rate_sel_o         <= 2'h0;
            second_summer_mode_o      <= 2'h0;
            record_src_sel_o          <= `REC_SRC_SECOND_SUMMING_AMP;
            mic_gain_amp_power_down_o <= 1'b0;
            input_source_sel_o        <= 1'b0;
            volume_input_sel_o        <= 2'h0;
            attenuator_power_down_o   <= 1'b0;
            attenuation_level_o       <= 3'h0;
            output_path_sel_o         <= 2'h0;
            speaker_drive_mode_o      <= 2'h0;
            analog_out_sel_o          <= 3'h0;
            analog_out_power_down_o   <= 1'b0;
        end
        else
        begin
            first_mixer_input_sel_o <= w1[`W1_MIX1_HI:`W1_MIX1_LO];
            first_summer_mode_o <= w1[`W1_FIRST_SUMMING_AMP_HI:`W1_FIRST_SUMMING_AMP_LO];
            filter_input_sel_o <= w1[`W1_FILT_SEL];
            filter_power_down_o <= w1[`W1_FILT_PD];
            sample_rate_sel_o <= w1[`W1_RATE_HI:`W1_RATE_LO];
            second_summer_mode_o <= w1[`W1_SECOND_SUMMING_AMP_HI:`W1_SECOND_SUMMING_AMP_LO];
            record_src_sel_o <= `REC_SRC_SECOND_SUMMING_AMP;
            mic_gain_amp_power_down_o <= w1[`W1_MIC_PD];
            input_source_sel_o <= w0[`W0_IN_SRC_SEL];
            volume_input_sel_o <= w1[`W1_VOL_HI:`W1_VOL_LO];
            attenuator_power_down_o <= w0[`W0_ATTN_PD];
            attenuation_level_o <= w1[`W1_ATTN_HI:`W1_ATTN_LO];
            output_path_sel_o <= w0[`W0_OUT_SEL_HI:`W0_OUT_SEL_LO];
            speaker_drive_mode_o <=
                w0[`W0_SPK_MODE_HI:`W0_SPK_MODE_LO];
            analog_out_sel_o <= w0[`W0_AOUT_SEL_HI:`W0_AOUT_SEL_LO];
            analog_out_power_down_o <= w0[`W0_AOUT_PD];
        end
    end
endmodule
`default_nettype wire

// file: tb/audio_path_checker.sv
`timescale 1ns/1ns
`default_nettype none
// Each decoded control trails its word field by one edge
module audio_path_checker
(
    input wire logic        clock_i,
    input wire logic        reset_n_i,
    input wire logic        scl_i,
    input wire logic [15:0] audio_path_config_word1_o,
    input wire logic [1:0]  first_mixer_input_sel_o,
    input wire logic [1:0]  first_summer_mode_o,
    input wire logic        filter_input_sel_o,
    input wire logic        filter_power_down_o,
    input wire logic [1:0]  sample_rate_sel_o,
    input wire logic [1:0]  second_summer_mode_o,
    input wire logic        mic_gain_amp_power_down_o
);
    wire [15:0] w1 = audio_path_config_word1_o; // Short alias
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    property p_mix; first_mixer_input_sel_o == $past(w1[10:9]); endproperty
    a_mix: assert property (p_mix) else $error("mixer select");
    property p_first_summing_amp; first_summer_mode_o == $past(w1[8:7]); endproperty
    a_first_summing_amp: assert property (p_first_summing_amp) else $error("summer1 mode");
    property p_fsel; filter_input_sel_o == $past(w1[4]); endproperty
    a_fsel: assert property (p_fsel) else $error("filter select");
    property p_fpd; filter_power_down_o == $past(w1[1]); endproperty
    a_fpd: assert property (p_fpd) else $error("filter power");
    property p_rate; sample_rate_sel_o == $past(w1[3:2]); endproperty
    a_rate: assert property (p_rate) else $error("sample rate");
    property p_second_summing_amp; second_summer_mode_o == $past(w1[6:5]); endproperty
    a_second_summing_amp: assert property (p_second_summing_amp) else $error("summer2 mode");
    property p_mic; mic_gain_amp_power_down_o == $past(w1[0]); endproperty
    a_mic: assert property (p_mic) else $error("mic power");
    // A word may only move while the commit clock is high
    property p_hold; !$stable(w1) |-> $past(scl_i); endproperty
    a_hold: assert property (p_hold) else $error("word moved");
    c_call: cover property (w1 == 16'h00c5);
    c_play: cover property (w1 == 16'h59d1);
    c_fsel: cover property ($rose(filter_input_sel_o));
endmodule
bind audio_path_config_decode audio_path_checker
    audio_path_checker_inst (.*);
`default_nettype wire

// file: tb/host_model.sv
`timescale 1ns/1ns
`default_nettype none
// Host side: stages words on the strobes, commits on one SCL rise
module host_model
(
    input  wire logic        clock_i, // System clock
    output var  logic        scl_o,   // Idles low between commits
    output var  logic        load0_o, // Word0 strobe
    output var  logic        load1_o, // Word1 strobe
    output var  logic [15:0] data0_o, // Word0 data
    output var  logic [15:0] data1_o  // Word1 data
);
    initial {scl_o, load0_o, load1_o, data0_o, data1_o} = '0;
    // Word1 alone is sent only when word0 is unchanged
    task send(input logic both, commit, input logic [15:0] w0, w1);
        @(posedge clock_i);
        if (both)
        begin
            load0_o <= 1'b1;
            data0_o <= w0;
            @(posedge clock_i);
            load0_o <= 1'b0;
            data0_o <= ~w0; // Stale data is inverted, not held
        end
        load1_o <= 1'b1;
        data1_o <= w1;
        @(posedge clock_i);
        load1_o <= 1'b0;
        data1_o <= ~w1;
        scl_o <= commit;
        repeat (4) @(posedge clock_i);
        scl_o <= 1'b0;
        repeat (4) @(posedge clock_i);
    endtask
endmodule
`default_nettype wire

// file: tb/audio_path_config_decode_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module audio_path_config_decode_tb_top;
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    wire scl_i, load_word0_i, load_word1_i;
    wire [15:0] load_data0_i, load_data1_i, dec0, dec1;
    wire [15:0] audio_path_config_word0_o, audio_path_config_word1_o;
    wire [1:0] first_mixer_input_sel_o, first_summer_mode_o;
    wire [1:0] second_summer_mode_o, volume_input_sel_o, sample_rate_sel_o;
    wire [1:0] output_path_sel_o, speaker_drive_mode_o;
    wire [2:0] attenuation_level_o, analog_out_sel_o;
    wire filter_input_sel_o, filter_power_down_o, record_src_sel_o;
    wire mic_gain_amp_power_down_o, input_source_sel_o;
    wire attenuator_power_down_o, analog_out_power_down_o;
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    int i;
    // Decoded controls packed back in word bit order
    assign dec1 = {volume_input_sel_o, attenuation_level_o,
        first_mixer_input_sel_o, first_summer_mode_o, second_summer_mode_o,
        filter_input_sel_o, sample_rate_sel_o, filter_power_down_o,
        mic_gain_amp_power_down_o};
    assign dec0 = {6'h00, input_source_sel_o, analog_out_sel_o,
        analog_out_power_down_o, output_path_sel_o, speaker_drive_mode_o,
        attenuator_power_down_o};
    audio_path_config_decode audio_path_config_decode_inst (.*);
    host_model host_model_inst (.clock_i(clock_i), .scl_o(scl_i),
        .load0_o(load_word0_i), .load1_o(load_word1_i),
        .data0_o(load_data0_i), .data1_o(load_data1_i));
    initial forever #10 clock_i = ~clock_i;
    // A hang is cut short well past the expected run length
    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            failures++;
            complete_run;
        end
    end
    task check(input logic [15:0] got, exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task expect_all(input logic [15:0] w0, w1);
        check(audio_path_config_word0_o, w0);
        check(audio_path_config_word1_o, w1);
        check(dec1, w1);
        check(dec0, {6'h00, w0[9:0]});
        check({15'h0000, record_src_sel_o}, 16'h0001);
    endtask
    task complete_run;
        $display("failures %0d checked %0d", failures, checked);
        if (failures == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Feed-through, call record, memo record, staged load, playback
    initial
    begin
        repeat (16) @(posedge clock_i);
        reset_n_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        expect_all(16'h0000, 16'h0000);
        host_model_inst.send(1'b1, 1'b1, 16'h440b, 16'h01e3);
        expect_all(16'h440b, 16'h01e3);
        host_model_inst.send(1'b0, 1'b1, 16'h0000, 16'h00c5);
        expect_all(16'h440b, 16'h00c5);
        host_model_inst.send(1'b1, 1'b1, 16'h2421, 16'h0148);
        expect_all(16'h2421, 16'h0148);
        host_model_inst.send(1'b1, 1'b0, 16'hffff, 16'h1234);
        expect_all(16'h2421, 16'h0148);
        host_model_inst.send(1'b1, 1'b1, 16'h2422, 16'h59d1);
        expect_all(16'h2422, 16'h59d1);
        for (i = 0; i < 8; i++)
        begin
            host_model_inst.send(1'b0, 1'b1, 16'h0000,
                {2'b01, i[2:0], 11'h1d1});
            expect_all(16'h2422, {2'b01, i[2:0], 11'h1d1});
        end
        complete_run;
    end
endmodule
`default_nettype wire
